// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the data EEPROM access block.
// Assumes: Write cycle shortened to 5 clocks; one register access per cycle.
// Notes:   The write task leaves the strobe up so accesses can run back to back.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.svh"

module tb_top;
    localparam int          WCYC = 5;
    localparam logic [11:0] CTRL = `DEAC_ADDR_CONTROL;
    localparam logic [11:0] KEY  = `DEAC_ADDR_UNLOCK_KEY;
    localparam logic [11:0] DATA = `DEAC_ADDR_DATA_BYTE;
    localparam logic [11:0] ADR  = `DEAC_ADDR_ADDRESS_BYTE;
    logic        clk_sys;
    logic        resetn;
    logic [11:0] regAddr;
    logic        regWrEn;
    logic [7:0]  regWrData;
    logic        regRdEn;
    logic [7:0]  regRdData;
    logic        writeDoneFlag;
    logic        writeBusy;
    int          nErrors;
    int          checks;

    deac_top #(.WRITE_CYCLES(WCYC)) u_deac_top (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .regAddr       (regAddr),
        .regWrEn       (regWrEn),
        .regWrData     (regWrData),
        .regRdEn       (regRdEn),
        .regRdData     (regRdData),
        .writeDoneFlag (writeDoneFlag),
        .writeBusy     (writeBusy)
    );

    // ==========================================================================
    // Clock, watchdog and closing
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (2000) @(posedge clk_sys);
        nErrors++;
        finish_test();
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", nErrors, checks);
        if (nErrors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========================================================================
    // Bus tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrEn   <= 1'b1;
        regRdEn   <= 1'b0;
        regAddr   <= a;
        regWrData <= d;
    endtask

    task automatic idle();
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
    endtask

    // Read data is due just after the edge that takes the strobe
    task automatic rdChk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1 check(regRdData, exp);
    endtask

    task automatic flagChk(input logic [7:0] exp);
        idle();
        @(posedge clk_sys);
        #1 check({6'h00, writeBusy, writeDoneFlag}, exp);
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        #1 check({6'h00, writeBusy, writeDoneFlag}, 8'h00);
        rdChk(12'hFA5, 8'h00);
        rdChk(12'hFAA, 8'h00);
        rdChk(KEY, 8'h00);
        rdChk(CTRL, `DEAC_RESET_BYTE);
    endtask

    task automatic t_write();
        int i;
        wr(ADR, 8'h5A);
        wr(DATA, 8'hC3);
        wr(CTRL, 8'h04);
        wr(KEY, `DEAC_KEY_FIRST);
        wr(KEY, `DEAC_KEY_SECOND);
        wr(CTRL, 8'h06);
        flagChk(8'h02);
        // Locked registers: none of these may land
        wr(ADR, 8'h11);
        wr(DATA, 8'hEE);
        wr(CTRL, 8'h00);
        idle();
        for (i = 0; i < 20 && writeBusy !== 1'b0; i++)
            @(posedge clk_sys);
        flagChk(8'h01);
        rdChk(CTRL, 8'h14);
        rdChk(ADR, 8'h5A);
        rdChk(DATA, 8'hC3);
        wr(CTRL, 8'h14);
        flagChk(8'h01);
        wr(CTRL, 8'h04);
        flagChk(8'h00);
        wr(ADR, 8'h5A);
        wr(DATA, 8'h77);
        wr(CTRL, 8'h05);
        rdChk(DATA, 8'hC3);
        // Reads aimed at other memories leave the data register alone
        wr(ADR, 8'h11);
        wr(CTRL, 8'h81);
        wr(CTRL, 8'h45);
        rdChk(DATA, 8'hC3);
    endtask

    task automatic t_refused();
        logic [7:0] pre [4];
        logic [7:0] k1 [4];
        logic [7:0] k2 [4];
        logic [7:0] stb [4];
        pre = '{8'h00, 8'h00, 8'h04, 8'h04};
        k1  = '{8'h55, 8'h55, 8'hAA, 8'h55};
        k2  = '{8'hAA, 8'hAA, 8'h55, 8'h55};
        stb = '{8'h02, 8'h06, 8'h06, 8'h06};
        wr(ADR, 8'h5A);
        wr(DATA, 8'h3C);
        for (int n = 0; n < 4; n++) begin
            wr(CTRL, pre[n]);
            wr(KEY, k1[n]);
            wr(KEY, k2[n]);
            wr(CTRL, stb[n]);
            flagChk(8'h00);
        end
        // An access between the keys breaks the unlock
        wr(CTRL, 8'h04);
        wr(KEY, `DEAC_KEY_FIRST);
        rdChk(KEY, 8'h00);
        wr(KEY, `DEAC_KEY_SECOND);
        wr(CTRL, 8'h06);
        flagChk(8'h00);
        wr(CTRL, 8'h05);
        rdChk(DATA, 8'hC3);
        wr(CTRL, 8'h00);
        rdChk(CTRL, 8'h00);
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        nErrors   = 0;
        checks    = 0;
        resetn    = 1'b0;
        regAddr   = 12'h000;
        regWrEn   = 1'b0;
        regWrData = 8'h00;
        regRdEn   = 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_write();
        t_refused();
        idle();
        finish_test();
    end
endmodule
`default_nettype wire

// ---- hdl/deac_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the data EEPROM access block.
// Assumes: Byte-wide special-register space with 12-bit addresses.
// Notes:   Definitions only.
`ifndef DEAC_MAP_SVH
`define DEAC_MAP_SVH

// ==========================================================================
// Register offsets
`define DEAC_ADDR_CONTROL      12'hFA6
`define DEAC_ADDR_UNLOCK_KEY   12'hFA7
`define DEAC_ADDR_DATA_BYTE    12'hFA8
`define DEAC_ADDR_ADDRESS_BYTE 12'hFA9

// ==========================================================================
// Control field positions
`define DEAC_BIT_MEMORY_SELECT 7
`define DEAC_BIT_CONFIG_SELECT 6
`define DEAC_BIT_DONE_FLAG     4
`define DEAC_BIT_WRITE_ENABLE  2
`define DEAC_BIT_WRITE_STROBE  1
`define DEAC_BIT_READ_STROBE   0

// ==========================================================================
// Unlock keys and reset values
`define DEAC_KEY_FIRST         8'h55
`define DEAC_KEY_SECOND        8'hAA
`define DEAC_RESET_BYTE        8'h00

// ==========================================================================
// Write cycle time
`define DEAC_WRITE_TIME_US     4
`define DEAC_CLK_MHZ           25
`define DEAC_WRITE_CYCLES      (`DEAC_WRITE_TIME_US * `DEAC_CLK_MHZ)

`endif

// ---- hdl/deac_pkg.sv ----
// Purpose: Types of the data EEPROM access block.
// Assumes: Nothing beyond the map header.
// Notes:   Unlock sequence tracker states.
`default_nettype none
package deac_pkg;
    typedef enum logic [1:0] {
        DEAC_LOCKED,
        DEAC_KEY1_SEEN,
        DEAC_KEY2_SEEN
    } deac_unlock_t;
endpackage
`default_nettype wire

// ---- hdl/deac_top.sv ----
// Purpose: Data EEPROM access control: byte reads, protected byte writes, done flag.
// Assumes: One register access per cycle from the core; array holds 256 bytes.
// Notes:   Write cycle time is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.svh"

// Overview of operation
// - Addressed byte in data register next cycle.
// - Data register holds until read or write.
// - Write needs 55h then AAh then strobe.
// - Write starts only with enable latch set.
// - Write strobe blocked while enable latch clear.
// - Latch and strobe together never start write.
// - Hardware never clears the write enable latch.
// - Registers locked while a write runs; done flag still clearable.
// - Completion clears strobe and sets done flag.
// - Done flag stays until software clears it.
// - Unimplemented addresses read as zero.
module deac_top #(
    parameter int WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [11:0] regAddr,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    output logic             writeDoneFlag,
    output logic             writeBusy
);

    // ======================================================================
    // Reset release
    logic rstSync1_q;
    logic rstSync2_q;
    logic rstn;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rstn = rstSync2_q;

    // ======================================================================
    // Storage array
    logic [7:0] eepromArray [0:255];

    // ======================================================================
    // Register state
    logic [7:0]              addressByte_q, addressByte_d;
    logic [7:0]              dataByte_q, dataByte_d;
    logic                    memorySelect_q, memorySelect_d;
    logic                    configSpaceSelect_q, configSpaceSelect_d;
    logic                    writeEnableLatch_q, writeEnableLatch_d;
    logic                    writeStrobe_q, writeStrobe_d;
    logic                    doneFlag_q, doneFlag_d;
    // Sixteen count bits leave room for a slow clock and a long write
    logic [15:0]             writeCount_q, writeCount_d;
    deac_pkg::deac_unlock_t  unlock_q, unlock_d;
    logic                    selCtrl, selKey, selData, selAddr;
    logic                    readFire, writeStart, writeFinish;

    assign selCtrl = regWrEn && (regAddr == `DEAC_ADDR_CONTROL);
    assign selKey  = regWrEn && (regAddr == `DEAC_ADDR_UNLOCK_KEY);
    assign selData = regWrEn && (regAddr == `DEAC_ADDR_DATA_BYTE);
    assign selAddr = regWrEn && (regAddr == `DEAC_ADDR_ADDRESS_BYTE);

    // Reads of the array only when data memory is selected and no write runs
    assign readFire = selCtrl && !writeStrobe_q && regWrData[`DEAC_BIT_READ_STROBE]
                      && !regWrData[`DEAC_BIT_MEMORY_SELECT] && !regWrData[`DEAC_BIT_CONFIG_SELECT];
    // Latch must already be set; the new value in the same write does not count
    assign writeStart = selCtrl && !writeStrobe_q && regWrData[`DEAC_BIT_WRITE_STROBE]
                        && writeEnableLatch_q && (unlock_q == deac_pkg::DEAC_KEY2_SEEN);
    assign writeFinish = writeStrobe_q && (writeCount_q == 16'(WRITE_CYCLES - 1));

    always_comb begin
        addressByte_d       = addressByte_q;
        dataByte_d          = dataByte_q;
        memorySelect_d      = memorySelect_q;
        configSpaceSelect_d = configSpaceSelect_q;
        writeEnableLatch_d  = writeEnableLatch_q;
        writeStrobe_d       = writeStrobe_q;
        doneFlag_d          = doneFlag_q;
        writeCount_d        = writeCount_q;
        unlock_d            = unlock_q;
        // Any access other than the exact sequence breaks the unlock
        if (regWrEn || regRdEn) begin
            unlock_d = deac_pkg::DEAC_LOCKED;
        end
        if (selKey) begin
            unique case (unlock_q)
                deac_pkg::DEAC_LOCKED:    unlock_d = (regWrData == `DEAC_KEY_FIRST) ?
                                                     deac_pkg::DEAC_KEY1_SEEN : deac_pkg::DEAC_LOCKED;
                deac_pkg::DEAC_KEY1_SEEN: unlock_d = (regWrData == `DEAC_KEY_SECOND) ?
                                                     deac_pkg::DEAC_KEY2_SEEN : deac_pkg::DEAC_LOCKED;
                deac_pkg::DEAC_KEY2_SEEN: unlock_d = deac_pkg::DEAC_LOCKED;
            endcase
        end
        if (!writeStrobe_q) begin
            if (selAddr) begin
                addressByte_d = regWrData;
            end
            if (selData) begin
                dataByte_d = regWrData;
            end
            if (selCtrl) begin
                memorySelect_d      = regWrData[`DEAC_BIT_MEMORY_SELECT];
                configSpaceSelect_d = regWrData[`DEAC_BIT_CONFIG_SELECT];
                writeEnableLatch_d  = regWrData[`DEAC_BIT_WRITE_ENABLE];
                // Done flag can only be cleared by software, never set by it
                if (!regWrData[`DEAC_BIT_DONE_FLAG]) begin
                    doneFlag_d = 1'b0;
                end
            end
        end else if (selCtrl && !regWrData[`DEAC_BIT_DONE_FLAG]) begin
            doneFlag_d = 1'b0;
        end
        if (readFire) begin
            dataByte_d = eepromArray[addressByte_q];
        end
        if (writeStart) begin
            writeStrobe_d = 1'b1;
            writeCount_d  = '0;
        end else if (writeStrobe_q) begin
            writeCount_d = writeCount_q + 16'h0001;
        end
        if (writeFinish) begin
            writeStrobe_d = 1'b0;
            doneFlag_d    = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addressByte_q       <= `DEAC_RESET_BYTE;
            dataByte_q          <= `DEAC_RESET_BYTE;
            memorySelect_q      <= 1'b0;
            configSpaceSelect_q <= 1'b0;
            writeEnableLatch_q  <= 1'b0;
            writeStrobe_q       <= 1'b0;
            doneFlag_q          <= 1'b0;
            writeCount_q        <= 16'h0000;
            unlock_q            <= deac_pkg::DEAC_LOCKED;
        end else begin
            addressByte_q       <= addressByte_d;
            dataByte_q          <= dataByte_d;
            memorySelect_q      <= memorySelect_d;
            configSpaceSelect_q <= configSpaceSelect_d;
            writeEnableLatch_q  <= writeEnableLatch_d;
            writeStrobe_q       <= writeStrobe_d;
            doneFlag_q          <= doneFlag_d;
            writeCount_q        <= writeCount_d;
            unlock_q            <= unlock_d;
        end
    end

    // Array contents are not reset, as in real nonvolatile memory
    always_ff @(posedge clk_sys) begin
        if (writeFinish) begin
            eepromArray[addressByte_q] <= dataByte_q;
        end
    end

    // ======================================================================
    // Read port
    logic [7:0] ctrlByte;
    logic [7:0] rdData_d, rdData_q;

    // Registered read data holds until the next read strobe
    always_comb begin
        ctrlByte = 8'h00;
        ctrlByte[`DEAC_BIT_MEMORY_SELECT] = memorySelect_q;
        ctrlByte[`DEAC_BIT_CONFIG_SELECT] = configSpaceSelect_q;
        ctrlByte[`DEAC_BIT_DONE_FLAG]     = doneFlag_q;
        ctrlByte[`DEAC_BIT_WRITE_ENABLE]  = writeEnableLatch_q;
        ctrlByte[`DEAC_BIT_WRITE_STROBE]  = writeStrobe_q;
        rdData_d = rdData_q;
        if (regRdEn) begin
            unique case (regAddr)
                `DEAC_ADDR_CONTROL:      rdData_d = ctrlByte;
                `DEAC_ADDR_DATA_BYTE:    rdData_d = dataByte_q;
                `DEAC_ADDR_ADDRESS_BYTE: rdData_d = addressByte_q;
                default:                 rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData     = rdData_q;
    assign writeDoneFlag = doneFlag_q;
    assign writeBusy     = writeStrobe_q;

    // ======================================================================
    // Assertions
    sequence s_key2Armed;
        unlock_q == deac_pkg::DEAC_KEY2_SEEN;
    endsequence

    a_start_needs_unlock: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(writeStrobe_q) |-> $past(unlock_q) == deac_pkg::DEAC_KEY2_SEEN)
        else $error("write started without unlock sequence");

    a_start_needs_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(writeStrobe_q) |-> $past(writeEnableLatch_q))
        else $error("write started with enable latch clear");

    a_strobe_blocked: assert property (@(posedge clk_sys) disable iff (!rstn)
        !writeEnableLatch_q && !writeStrobe_q |=> !writeStrobe_q)
        else $error("strobe set with latch clear");

    a_same_write_blocked: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_key2Armed ##0 (selCtrl && !writeEnableLatch_q && !writeStrobe_q) |=> !writeStrobe_q)
        else $error("latch and strobe in one write started a write");

    a_latch_sw_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        !selCtrl |=> $stable(writeEnableLatch_q))
        else $error("enable latch changed without software write");

    a_lock_during_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeStrobe_q |=> $stable(addressByte_q) && $stable(dataByte_q) && $stable(writeEnableLatch_q))
        else $error("registers changed during write");

    a_finish_sets_done: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeFinish |=> !writeStrobe_q && doneFlag_q)
        else $error("write end did not clear strobe and set done");

    a_done_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
        doneFlag_q && !selCtrl |=> doneFlag_q)
        else $error("done flag cleared by hardware");

    a_read_next_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
        readFire |=> dataByte_q == $past(eepromArray[addressByte_q]))
        else $error("read data not loaded next cycle");

    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        regRdEn && regAddr != `DEAC_ADDR_CONTROL && regAddr != `DEAC_ADDR_DATA_BYTE
        && regAddr != `DEAC_ADDR_ADDRESS_BYTE |=> regRdData == 8'h00)
        else $error("unmapped address read nonzero");

    sequence s_otherAccess;
        regRdEn || (regWrEn && !selKey);
    endsequence

    a_unlock_broken: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_otherAccess |=> unlock_q == deac_pkg::DEAC_LOCKED)
        else $error("unlock survived an unrelated access");

    a_ctrl_locked: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeStrobe_q |=> $stable(memorySelect_q) && $stable(configSpaceSelect_q))
        else $error("control selects changed during write");

    a_strobe_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeStrobe_q && !writeFinish |=> writeStrobe_q)
        else $error("write strobe dropped before the end");

    a_write_bounded: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeStrobe_q |-> writeCount_q < 16'(WRITE_CYCLES))
        else $error("write ran past its cycle count");

    a_write_lands: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeFinish |=> eepromArray[addressByte_q] == dataByte_q)
        else $error("array not updated at write end");

    a_done_set_hw: assert property (@(posedge clk_sys) disable iff (!rstn)
        !writeFinish |=> !$rose(doneFlag_q))
        else $error("done flag set without a write end");

    a_done_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        selCtrl && !regWrData[`DEAC_BIT_DONE_FLAG] && !writeFinish |=> !doneFlag_q)
        else $error("software clear of done flag ignored");

    a_data_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        !readFire && !selData |=> $stable(dataByte_q))
        else $error("data register changed without read or write");

    a_data_readout: assert property (@(posedge clk_sys) disable iff (!rstn)
        regRdEn && regAddr == `DEAC_ADDR_DATA_BYTE |=> regRdData == $past(dataByte_q))
        else $error("data register read returned wrong byte");

    a_key_reads_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        regRdEn && regAddr == `DEAC_ADDR_UNLOCK_KEY |=> regRdData == 8'h00)
        else $error("unlock key read nonzero");

endmodule
`default_nettype wire
